/* common/hwrs_defs.vh */
// constants for the halt, wake-up and reset sequencer
`ifndef HWRS_DEFS_VH
`define HWRS_DEFS_VH
// register byte addresses on the avalon bus
`define HWRS_ADDR_CTRL 5'h00
`define HWRS_ADDR_STATUS 5'h04
`define HWRS_ADDR_WAKE_EN 5'h08
`define HWRS_ADDR_TIMER0_CONTROL 5'h0c
`define HWRS_ADDR_INTERRUPT_CONTROL 5'h10
`define HWRS_ADDR_WDSEL 5'h14
// control register bit positions (halt and wdclr fire on a one; wdosc and rtcen are held levels)
`define HWRS_CTRL_HALT 0
`define HWRS_CTRL_WDCLR 1
`define HWRS_CTRL_WDOSC 2
`define HWRS_CTRL_RTCEN 3
// status register bit positions
`define HWRS_ST_PDF 0
`define HWRS_ST_TO 1
`define HWRS_ST_HALT 2
`define HWRS_ST_BUSY 3
// reset values of loaded registers
`define HWRS_TIMER0_CONTROL_RST 8'h08
`define HWRS_INTERRUPT_CONTROL_RST 8'h00
`define HWRS_WDSEL_RST 8'h07
`define HWRS_PORT_RST 8'hff
`define HWRS_PG_RST 3'h7
`define HWRS_PC_RST 12'h000
// startup delay and option load delay, in system clock periods
`define HWRS_SST_CYCLES 1024
`define HWRS_OPT_LOAD_CYCLES 16
`define HWRS_INT_EXTRA_CYCLES 1
// sequencer states
`define HWRS_S_RUN 3'h0
`define HWRS_S_RST 3'h1
`define HWRS_S_OPT 3'h2
`define HWRS_S_HALT 3'h3
`define HWRS_S_WAKE 3'h4
`define HWRS_S_IRQ 3'h5
`endif

/* design/hwrs_sequencer.v */
// halt entry, wake-up and reset sequencing for an 8-bit controller core
//
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "hwrs_defs.vh"
module hwrs_sequencer #(
  parameter SST_CYCLES = `HWRS_SST_CYCLES,
  parameter OPT_CYCLES = `HWRS_OPT_LOAD_CYCLES,
  parameter NPORTS = 4
) (
  // clock and synchronous reset (power-up)
  input wire sys_clk,
  input wire srst,
  // avalon-mm slave
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // wake sources
  input wire external_reset_pin_n,
  input wire [7:0] port_a_in,
  input wire [2:0] irq_flags,
  input wire [2:0] irq_enables,
  input wire irq_master_en,
  input wire stack_full,
  input wire watchdog_overflow,
  // core side
  output reg core_run_q,
  output reg core_reset_q,
  output reg warm_reset_q,
  output reg irq_take_q,
  output reg sys_osc_en_q,
  output reg wdt_osc_en_q,
  output reg rtc_osc_en_q,
  output reg watchdog_clear_q,
  output reg [7:0] timer0_control_q,
  output reg [7:0] interrupt_control_q,
  output reg [7:0] watchdog_select_q,
  output reg [8*NPORTS-1:0] port_data_q,
  output reg [8*NPORTS-1:0] port_dir_q,
  output reg [2:0] port_g_data_q,
  output reg [2:0] port_g_dir_q,
  output reg [11:0] pc_reset_value_q
);
  // operating notes for whoever picks this block up next
  //
  // overall shape
  // - one sequencer state machine owns the core run and reset strobes
  // - a second process owns the register image loaded at full resets
  // - a third process answers the register bus with one wait state
  // - all outputs leave from flip-flops, so the core sees clean levels
  //
  // reset kinds
  // - power-up comes in on srst and clears both cause flags
  // - a pin edge in run keeps both cause flags as they were
  // - a pin edge in halt marks power-down set and timeout clear
  // - an overflow in run sets timeout and leaves power-down alone
  // - an overflow in halt sets timeout and keeps power-down set
  // - only the overflow in halt is a warm reset; all others are full
  //
  // full reset path
  // - core held in reset for the startup delay, then the option load
  // - register image reloaded every cycle while full init is pending
  // - core released only once the option load count has run out
  //
  // warm reset path
  // - only a one-cycle warm strobe goes to the core (pc and stack)
  // - the register image is left exactly as software last wrote it
  // - the dummy period still runs, but no option load follows
  //
  // halt entry
  // - taken only from run, at the edge where the bus answers
  // - stops the system oscillator enable and the core run strobe
  // - clears the watchdog when it runs from its own oscillator
  // - latches interrupt flags already pending, so they cannot wake
  //
  // wake sources in halt, in priority order
  // - pin edge first, since it must fully initialise the device
  // - watchdog overflow next, giving the warm reset
  // - new interrupt flags or an enabled port line falling
  //
  // interrupt wake
  // - vectored only when enabled, master enable set and stack has room
  // - otherwise resumes at the next instruction like a port wake
  // - the vectored case waits extra cycles past the dummy period
  //
  // hazards worth knowing
  // - the pin is edge detected; a pin held low does not retrigger
  // - the port edge detector resets high, matching the pulled-up idle
  // - overflow during the startup or dummy period is not acted on
  // - the halt command is ignored outside run, by design
  // - a watchdog clear in the same write as halt still lets halt set
  //   the power-down flag, since the halt branch is assigned last
  //
  // counter sizing
  // - one shared counter covers startup, option load and extra cycles
  // - its width must hold the largest of these counts minus one
  // - shrinking the startup count for simulation keeps the same width
  //
  // bus side
  // - waitrequest is high while idle and drops for one answer cycle
  // - config writes land at the edge the request is first seen
  // - commands fire at the answer edge, so they act exactly once
  // - read data is loaded on the first edge and stands with the answer
  // - unmapped reads return zero and unmapped writes change nothing
  //
  // status word
  // - bit 0 power-down flag, bit 1 timeout flag
  // - bit 2 halted, bit 3 busy in any non-run state
  //
  // oscillator enables
  // - the watchdog oscillator enable follows the software select
  // - the rtc oscillator enable follows its software enable, halt or not
  // - the system oscillator enable drops only while halted
  //
  // limitations
  // - the watchdog divider and prescaler themselves live elsewhere
  // - only the clear strobe is produced here
  // - the interrupt priority and vector choice live in the core
  // - stack depth is reported by the core as a single full flag
  localparam CW = 11;
  // derived counts, cut to the counter width on purpose
  localparam integer SST_M1 = SST_CYCLES - 1;
  localparam integer OPT_M1 = OPT_CYCLES - 1;
  localparam integer IRQ_M1 = `HWRS_INT_EXTRA_CYCLES - 1;
  localparam [CW-1:0] SST_LAST = SST_M1[CW-1:0];
  localparam [CW-1:0] OPT_LAST = OPT_M1[CW-1:0];
  localparam [CW-1:0] IRQ_LAST = IRQ_M1[CW-1:0];

  reg [2:0] state_q; // sequencer state
  reg [CW-1:0] cnt_q; // delay counter
  reg power_down_flag_q;
  reg timeout_flag_q;
  reg [7:0] wake_en_q; // per-bit port A wake enable
  reg [7:0] pa_prev_q; // previous port A sample for edge detect
  reg [2:0] irq_blk_q; // flags already set at halt entry
  reg wdosc_sel_q; // watchdog clocked from own oscillator
  reg rtc_en_q; // rtc oscillator enabled
  reg pin_prev_q; // previous reset pin level
  reg wake_irq_q; // wake came from vectored interrupt
  reg full_init_q; // pending full register init

  wire acc = avs_read | avs_write;
  wire [31:0] wd = avs_writedata;
  wire pin_fall = pin_prev_q & ~external_reset_pin_n;
  wire [7:0] pa_fall = pa_prev_q & ~port_a_in & wake_en_q;
  wire [2:0] irq_new = irq_flags & ~irq_blk_q;
  wire halt_cmd = avs_write & ~avs_waitrequest & (avs_address == `HWRS_ADDR_CTRL)
                  & wd[`HWRS_CTRL_HALT] & (state_q == `HWRS_S_RUN);
  wire wdclr_cmd = avs_write & ~avs_waitrequest & (avs_address == `HWRS_ADDR_CTRL)
                   & wd[`HWRS_CTRL_WDCLR];

  // one-cycle-wait avalon decode; reads answer one cycle after request
  always @(posedge sys_clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~(acc & avs_waitrequest);
      if (avs_read & avs_waitrequest) begin
        case (avs_address)
          `HWRS_ADDR_STATUS: avs_readdata <= {28'h0000000,
            state_q != `HWRS_S_RUN, state_q == `HWRS_S_HALT,
            timeout_flag_q, power_down_flag_q};
          `HWRS_ADDR_CTRL: avs_readdata <= {28'h0000000, rtc_en_q, wdosc_sel_q, 2'b00};
          `HWRS_ADDR_WAKE_EN: avs_readdata <= {24'h000000, wake_en_q};
          `HWRS_ADDR_TIMER0_CONTROL: avs_readdata <= {24'h000000, timer0_control_q};
          `HWRS_ADDR_INTERRUPT_CONTROL: avs_readdata <= {24'h000000, interrupt_control_q};
          `HWRS_ADDR_WDSEL: avs_readdata <= {24'h000000, watchdog_select_q};
          default: avs_readdata <= 32'h0000_0000; // unmapped reads zero
        endcase
      end
    end
  end

  // sequencer: reset, option load, halt, wake dummy period
  always @(posedge sys_clk) begin
    if (srst) begin
      state_q <= `HWRS_S_RST;
      cnt_q <= {CW{1'b0}};
      power_down_flag_q <= 1'b0;
      timeout_flag_q <= 1'b0;
      full_init_q <= 1'b1;
      wake_irq_q <= 1'b0;
      irq_blk_q <= 3'h0;
      pa_prev_q <= 8'hff;
      pin_prev_q <= 1'b1;
      wake_en_q <= 8'h00;
      wdosc_sel_q <= 1'b1;
      rtc_en_q <= 1'b0;
      core_run_q <= 1'b0;
      core_reset_q <= 1'b1;
      warm_reset_q <= 1'b0;
      irq_take_q <= 1'b0;
      sys_osc_en_q <= 1'b1;
      wdt_osc_en_q <= 1'b1;
      rtc_osc_en_q <= 1'b0;
      watchdog_clear_q <= 1'b1;
    end else begin
      pa_prev_q <= port_a_in;
      pin_prev_q <= external_reset_pin_n;
      watchdog_clear_q <= 1'b0;
      warm_reset_q <= 1'b0;
      irq_take_q <= 1'b0;
      rtc_osc_en_q <= rtc_en_q;
      wdt_osc_en_q <= wdosc_sel_q;
      // software config writes
      if (avs_write & avs_waitrequest) begin
        if (avs_address == `HWRS_ADDR_CTRL) begin
          wdosc_sel_q <= wd[`HWRS_CTRL_WDOSC];
          rtc_en_q <= wd[`HWRS_CTRL_RTCEN];
        end
        if (avs_address == `HWRS_ADDR_WAKE_EN)
          wake_en_q <= wd[7:0];
      end
      if (wdclr_cmd) begin
        power_down_flag_q <= 1'b0;
        watchdog_clear_q <= 1'b1;
      end
      case (state_q)
        `HWRS_S_RUN: begin
          if (pin_fall) begin
            // pin reset in normal run: flags unchanged
            state_q <= `HWRS_S_RST;
            cnt_q <= {CW{1'b0}};
            full_init_q <= 1'b1;
            core_run_q <= 1'b0;
            core_reset_q <= 1'b1;
            watchdog_clear_q <= 1'b1;
          end else if (watchdog_overflow) begin
            timeout_flag_q <= 1'b1;
            state_q <= `HWRS_S_RST;
            cnt_q <= {CW{1'b0}};
            full_init_q <= 1'b1;
            core_run_q <= 1'b0;
            core_reset_q <= 1'b1;
            watchdog_clear_q <= 1'b1;
          end else if (halt_cmd) begin
            power_down_flag_q <= 1'b1;
            timeout_flag_q <= 1'b0;
            irq_blk_q <= irq_flags;
            watchdog_clear_q <= wdosc_sel_q;
            sys_osc_en_q <= 1'b0;
            core_run_q <= 1'b0;
            state_q <= `HWRS_S_HALT;
          end
        end
        `HWRS_S_RST: begin
          // startup delay inside the reset period
          if (cnt_q == SST_LAST) begin
            cnt_q <= {CW{1'b0}};
            state_q <= `HWRS_S_OPT;
          end else
            cnt_q <= cnt_q + 1'b1;
        end
        `HWRS_S_OPT: begin
          // option load delay, only after full resets
          if (cnt_q == OPT_LAST) begin
            cnt_q <= {CW{1'b0}};
            full_init_q <= 1'b0;
            core_reset_q <= 1'b0;
            core_run_q <= 1'b1;
            state_q <= `HWRS_S_RUN;
          end else
            cnt_q <= cnt_q + 1'b1;
        end
        `HWRS_S_HALT: begin
          if (pin_fall) begin
            power_down_flag_q <= 1'b1;
            timeout_flag_q <= 1'b0;
            sys_osc_en_q <= 1'b1;
            state_q <= `HWRS_S_RST;
            cnt_q <= {CW{1'b0}};
            full_init_q <= 1'b1;
            core_reset_q <= 1'b1;
            watchdog_clear_q <= 1'b1;
          end else if (watchdog_overflow) begin
            timeout_flag_q <= 1'b1;
            warm_reset_q <= 1'b1;
            sys_osc_en_q <= 1'b1;
            wake_irq_q <= 1'b0;
            cnt_q <= {CW{1'b0}};
            state_q <= `HWRS_S_WAKE;
          end else if ((|irq_new) | (|pa_fall)) begin
            // port wake resumes next; interrupt vectored when allowed
            wake_irq_q <= (|(irq_new & irq_enables)) & irq_master_en
                          & ~stack_full;
            sys_osc_en_q <= 1'b1;
            cnt_q <= {CW{1'b0}};
            state_q <= `HWRS_S_WAKE;
          end
        end
        `HWRS_S_WAKE: begin
          // dummy period, no option load on warm reset
          if (cnt_q == SST_LAST) begin
            cnt_q <= {CW{1'b0}};
            if (wake_irq_q)
              state_q <= `HWRS_S_IRQ;
            else begin
              core_run_q <= 1'b1;
              state_q <= `HWRS_S_RUN;
            end
          end else
            cnt_q <= cnt_q + 1'b1;
        end
        `HWRS_S_IRQ: begin
          // extra cycles before service routine entry
          if (cnt_q == IRQ_LAST) begin
            irq_take_q <= 1'b1;
            core_run_q <= 1'b1;
            state_q <= `HWRS_S_RUN;
          end else
            cnt_q <= cnt_q + 1'b1;
        end
        default: state_q <= `HWRS_S_RST;
      endcase
    end
  end

  // register image: full init on all but warm reset
  always @(posedge sys_clk) begin
    if (srst | full_init_q) begin
      timer0_control_q <= `HWRS_TIMER0_CONTROL_RST;
      interrupt_control_q <= `HWRS_INTERRUPT_CONTROL_RST;
      watchdog_select_q <= `HWRS_WDSEL_RST;
      port_data_q <= {4*NPORTS{2'b11}};
      port_dir_q <= {4*NPORTS{2'b11}};
      port_g_data_q <= `HWRS_PG_RST;
      port_g_dir_q <= `HWRS_PG_RST;
      pc_reset_value_q <= `HWRS_PC_RST;
    end else if (avs_write & avs_waitrequest) begin
      // software updates; warm reset leaves all of these
      case (avs_address)
        `HWRS_ADDR_TIMER0_CONTROL: timer0_control_q <= {wd[7:6], 1'b0, wd[4:0]};
        `HWRS_ADDR_INTERRUPT_CONTROL: interrupt_control_q <= {1'b0, wd[6:0]};
        `HWRS_ADDR_WDSEL: watchdog_select_q <= wd[7:0];
        default: pc_reset_value_q <= pc_reset_value_q;
      endcase
    end
  end
endmodule

/* test/hwrs_checker.sv */
// port assertions for the halt and reset sequencer
`timescale 1ns/10ps
module hwrs_checker (
  // clock and reset
  input wire sys_clk,
  input wire srst,
  // bus handshake
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  // core side
  input wire core_run_q,
  input wire core_reset_q,
  input wire warm_reset_q,
  input wire sys_osc_en_q,
  input wire [7:0] timer0_control_q,
  input wire [7:0] interrupt_control_q,
  input wire [7:0] watchdog_select_q,
  input wire [31:0] port_data_q,
  input wire [31:0] port_dir_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // oscillator restart, then the dummy period
  sequence s_osc_back;
    $rose(sys_osc_en_q);
  endsequence
  sequence s_core_held;
    !core_run_q [*8];
  endsequence
  a_dummy_period: assert property (s_osc_back |-> s_core_held) else $error("run in dummy");
  a_halt_stops: assert property (!sys_osc_en_q |-> !core_run_q) else $error("run in halt");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no bus answer");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait low long");
  a_reset_loads: assert property ($fell(srst) |-> timer0_control_q == 8'h08 &&
    interrupt_control_q == 8'h00 && watchdog_select_q == 8'h07 && port_data_q == 32'hffffffff
    && port_dir_q == 32'hffffffff) else $error("reset values");
  a_reset_holds: assert property ($fell(srst) |-> core_reset_q && !core_run_q)
    else $error("core not held");
  a_warm_keeps: assert property (warm_reset_q |=> $stable(port_data_q) && $stable(port_dir_q) &&
    $stable(timer0_control_q) && $stable(watchdog_select_q)) else $error("warm changed regs");
  a_warm_light: assert property (warm_reset_q |-> !core_reset_q) else $error("warm was full");
  a_run_clean: assert property (core_run_q |-> !core_reset_q && sys_osc_en_q)
    else $error("run while reset");
endmodule

/* test/hwrs_far_model.sv */
// far-side model: reset pin, port a lines and watchdog overflow
`timescale 1ns/10ps
module hwrs_far_model (
  // clock
  input wire sys_clk,
  // toward the sequencer
  output logic external_reset_pin_n,
  output logic [7:0] port_a_in,
  output logic watchdog_overflow
);
  // idle: pin released high, port lines pulled high
  initial begin
    external_reset_pin_n = 1'b1;
    port_a_in = 8'hff;
    watchdog_overflow = 1'b0;
  end
  // pin pulled low for four cycles
  task pin_reset;
    begin
      @(posedge sys_clk);
      external_reset_pin_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      external_reset_pin_n <= 1'b1;
    end
  endtask
  // falling edge on one port line, back high later
  task port_fall(input int b);
    begin
      @(posedge sys_clk);
      port_a_in[b] <= 1'b0;
      repeat (2) @(posedge sys_clk);
      port_a_in[b] <= 1'b1;
    end
  endtask
  // one-cycle overflow event
  task overflow;
    begin
      @(posedge sys_clk);
      watchdog_overflow <= 1'b1;
      @(posedge sys_clk);
      watchdog_overflow <= 1'b0;
    end
  endtask
endmodule

/* test/tb_top.sv */
// self-checking bench for the halt and reset sequencer
`timescale 1ns/10ps
module tb_top;
  localparam int STARTUP_DELAY_TIMER = 8;
  logic sys_clk, srst, avs_read, avs_write, avs_waitrequest, irq_master_en, stack_full;
  logic external_reset_pin_n, watchdog_overflow, core_run_q, core_reset_q, warm_reset_q;
  logic irq_take_q, sys_osc_en_q, wdt_osc_en_q, rtc_osc_en_q, watchdog_clear_q;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, port_data_q, port_dir_q, q;
  logic [7:0] port_a_in, timer0_control_q, interrupt_control_q, watchdog_select_q;
  logic [2:0] irq_flags, irq_enables, port_g_data_q, port_g_dir_q;
  logic [11:0] pc_reset_value_q;
  logic seen_take;
  int n_mismatch, checked, cyc, n;
  hwrs_sequencer #(.SST_CYCLES(STARTUP_DELAY_TIMER), .OPT_CYCLES(2)) DUT (.sys_clk(sys_clk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .external_reset_pin_n(external_reset_pin_n),
    .port_a_in(port_a_in), .irq_flags(irq_flags), .irq_enables(irq_enables),
    .irq_master_en(irq_master_en), .stack_full(stack_full),
    .watchdog_overflow(watchdog_overflow), .core_run_q(core_run_q),
    .core_reset_q(core_reset_q), .warm_reset_q(warm_reset_q), .irq_take_q(irq_take_q),
    .sys_osc_en_q(sys_osc_en_q), .wdt_osc_en_q(wdt_osc_en_q), .rtc_osc_en_q(rtc_osc_en_q),
    .watchdog_clear_q(watchdog_clear_q), .timer0_control_q(timer0_control_q),
    .interrupt_control_q(interrupt_control_q), .watchdog_select_q(watchdog_select_q),
    .port_data_q(port_data_q), .port_dir_q(port_dir_q), .port_g_data_q(port_g_data_q),
    .port_g_dir_q(port_g_dir_q), .pc_reset_value_q(pc_reset_value_q));
  hwrs_far_model m (.sys_clk(sys_clk), .external_reset_pin_n(external_reset_pin_n),
    .port_a_in(port_a_in), .watchdog_overflow(watchdog_overflow));
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // cycle ceiling and interrupt-take watch
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (irq_take_q === 1'b1) seen_take <= 1'b1;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  task chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  // one bus transfer, held until waitrequest is sampled low
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // cycles until the core runs again
  task wait_run;
    n = 0;
    while (core_run_q !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  // halt command, oscillator select kept on
  task halt;
    bus(1'b1, 5'h00, 32'hd);
    repeat (3) @(posedge sys_clk);
  endtask
  task s_reset;
    chk(timer0_control_q === 8'h08 && watchdog_select_q === 8'h07, "t0/wdsel");
    chk(port_data_q === 32'hffffffff && port_g_dir_q === 3'h7, "ports");
    chk(pc_reset_value_q === 12'h000 && core_reset_q === 1'b1, "pc");
    chk(interrupt_control_q === 8'h00 && port_dir_q === 32'hffffffff, "interrupt_control/dir");
    wait_run();
    chk(n >= STARTUP_DELAY_TIMER + 2 - 1, "short start");
    bus(1'b0, 5'h04, 32'h0);
    chk(q[1:0] === 2'b00, "power-up flags");
    bus(1'b0, 5'h18, 32'h0);
    chk(q === 32'h0, "unmapped");
  endtask
  task s_port_wake;
    bus(1'b1, 5'h0c, 32'h55);
    bus(1'b1, 5'h08, 32'h01);
    halt();
    chk(sys_osc_en_q === 1'b0, "osc on in halt");
    chk(rtc_osc_en_q === 1'b1 && wdt_osc_en_q === 1'b1, "osc lost in halt");
    bus(1'b0, 5'h04, 32'h0);
    chk(q[2:0] === 3'b101, "halt flags");
    m.port_fall(1);
    repeat (20) @(posedge sys_clk);
    chk(core_run_q === 1'b0, "masked port woke");
    m.port_fall(0);
    wait_run();
    chk(n + 3 >= STARTUP_DELAY_TIMER && n <= STARTUP_DELAY_TIMER + 4, "wake delay");
    chk(timer0_control_q === 8'h55, "halt lost reg");
  endtask
  task s_irq;
    irq_flags <= 3'b001;
    halt();
    repeat (20) @(posedge sys_clk);
    chk(core_run_q === 1'b0, "stale flag woke");
    seen_take <= 1'b0;
    irq_flags <= 3'b011;
    wait_run();
    repeat (4) @(posedge sys_clk);
    chk(seen_take === 1'b1 && n + 3 >= STARTUP_DELAY_TIMER, "no vector");
    irq_flags <= 3'b000;
  endtask
  task s_wdt(input logic in_halt, input logic [1:0] fl, input logic [7:0] t0);
    bus(1'b1, 5'h0c, 32'h55);
    if (in_halt) halt();
    m.overflow();
    repeat (2) @(posedge sys_clk);
    wait_run();
    bus(1'b0, 5'h04, 32'h0);
    chk(q[1:0] === fl && timer0_control_q === t0, "overflow");
  endtask
  task s_pin;
    halt();
    m.pin_reset();
    repeat (2) @(posedge sys_clk);
    wait_run();
    bus(1'b0, 5'h04, 32'h0);
    chk(q[1:0] === 2'b01 && timer0_control_q === 8'h08, "pin in halt");
  endtask
  task close_out;
    if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // main sequence
  initial begin
    {srst, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 39'h0};
    {irq_flags, irq_enables, irq_master_en, stack_full} = {3'h0, 3'h7, 1'b1, 1'b0};
    {cyc, n_mismatch, checked, seen_take} = 0;
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    s_reset();
    s_port_wake();
    s_irq();
    s_wdt(1'b1, 2'b11, 8'h55);
    bus(1'b1, 5'h00, 32'h6);
    bus(1'b0, 5'h04, 32'h0);
    chk(q[0] === 1'b0, "clear kept flag");
    s_pin();
    s_wdt(1'b0, 2'b11, 8'h08);
    close_out();
  end
endmodule
bind hwrs_sequencer hwrs_checker u_chk (.sys_clk(sys_clk), .srst(srst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .core_run_q(core_run_q),
  .core_reset_q(core_reset_q), .warm_reset_q(warm_reset_q), .sys_osc_en_q(sys_osc_en_q),
  .timer0_control_q(timer0_control_q), .interrupt_control_q(interrupt_control_q),
  .watchdog_select_q(watchdog_select_q), .port_data_q(port_data_q), .port_dir_q(port_dir_q));
